// ===== sae_exec.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - block transfers: base and list low only
// - block writeback always, except load containing base
// - block base must be word aligned
// - store with base listed: base lowest
// - block, push, pop keep flags
// - push and pop need nonempty list
// - stack: lowest register at lowest address
// - push tops at sp-4, pop from sp
// - sp ends at lowest push, above pop
// - pop into pc branches, bit0 sets t
// - stack lists low, plus lr/pc
// - missing destination defaults to first operand
// - add-with-carry adds carry, sets all flags
// - plain add/sub keep flags; s-forms set
// - negate is zero minus operand, sets flags
// - subtract-with-carry borrows when carry clear
// - plain subtract takes immediate only
// - carry and imm8 forms: low, rd equals rs
// - register add: any reg, rd=rs, not pc,pc
// - sp/pc imm to 1020, sp imm 508
// - imm3 and three-register forms: any low
// - block words ascend by four, base+4n
module sae_exec
   import sae_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [SAE_AW-1:0] i_paddr,
   input wire logic [SAE_DW-1:0] i_pwdata,
   output logic [SAE_DW-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [SAE_DW-1:0] o_mem_addr,
   output logic [SAE_DW-1:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [SAE_DW-1:0] i_mem_rdata,
   output logic o_branch
);
   sae_state_type state_reg;
   sae_op_type op_reg;
   logic [3:0] rd_reg, rs_reg, rt_reg, idx_reg;
   logic [9:0] imm_reg;
   logic form_reg, wb_reg, tbit_reg, ill_reg, rdpend_reg;
   logic [8:0] list_reg;
   logic [3:0] flags_reg;
   logic [SAE_DW-1:0] addr_reg, end_reg, ra_data, rb_data;

   function automatic logic lo(input logic [3:0] r);
      return !r[SAE_HIGH_BIT];
   endfunction

   // lowest listed slot at or above from, or the end marker
   function automatic logic [3:0] next_idx(input logic [8:0] l, input logic [3:0] from);
      logic [3:0] r;
      r = SAE_LIST_END;
      for (int k = 8; k >= 0; k--)
      begin
         if (l[k] && (4'(k) >= from))
         begin
            r = 4'(k);
         end
      end
      return r;
   endfunction

   function automatic logic [3:0] count(input logic [8:0] l);
      logic [3:0] c;
      c = 4'h0;
      for (int k = 0; k <= 8; k++)
      begin
         c = c + {3'h0, l[k]};
      end
      return c;
   endfunction

   // slot 8 is lr for push and pc for pop
   function automatic logic [3:0] reg_of(input logic [3:0] i, input sae_op_type o);
      if (i == 4'(SAE_LIST_XTRA))
      begin
         return (o == SAE_PUSH) ? SAE_REG_LR : SAE_REG_PC;
      end
      return i;
   endfunction

   function automatic logic legal(input sae_op_type o, input logic [3:0] rd,
         input logic [3:0] rs, input logic [3:0] rt, input logic [9:0] imm,
         input logic form, input logic [8:0] l, input logic wb);
      logic low3, m4, lst_ok;
      low3 = lo(rd) && lo(rs) && lo(rt);
      m4 = (imm[1:0] == 2'h0);
      lst_ok = lo(rs) && !l[SAE_LIST_XTRA] && (l != 9'h0);
      case (o)
         SAE_ADC, SAE_SBC: return low3 && (rd == rs) && !form;
         SAE_ADDS, SAE_SUBF:
            return form ? (lo(rd) && lo(rs) && ((imm <= SAE_IMM3_MAX)
                  || ((imm <= SAE_IMM8_MAX) && (rd == rs)))) : low3;
         SAE_ADD:
            return form ? (((rs == SAE_REG_SP) || (rs == SAE_REG_PC)) && lo(rd) && m4
                  && (imm <= SAE_PCIMM_MAX))
                  || ((rd == SAE_REG_SP) && (rs == SAE_REG_SP) && m4
                  && (imm <= SAE_SPIMM_MAX)) || (lo(rd) && lo(rs) && (imm <= SAE_IMM3_MAX))
                  : ((rd == rs) && !((rs == SAE_REG_PC) && (rt == SAE_REG_PC)));
         SAE_SUB:
            return form && (((rd == SAE_REG_SP) && (rs == SAE_REG_SP) && m4
                  && (imm <= SAE_SPIMM_MAX)) || (lo(rd) && lo(rs) && (imm <= SAE_IMM3_MAX)));
         SAE_NEG: return lo(rd) && lo(rs);
         SAE_BLD: return lst_ok && (wb == !l[rs[2:0]]);
         SAE_BST: return lst_ok && wb && (!l[rs[2:0]] || (next_idx(l, 4'h0) == rs));
         SAE_PUSH, SAE_POP: return l != 9'h0;
         default: return 1'b0;
      endcase
   endfunction

   // apb decode
   wire busy = (state_reg != ST_IDLE);
   wire acc = i_psel && i_penable && !o_pready;
   wire hit_ctrl = (i_paddr == SAE_OFF_CTRL);
   wire hit_list = (i_paddr == SAE_OFF_LIST);
   wire hit_stat = (i_paddr == SAE_OFF_STAT);
   wire hit_flag = (i_paddr == SAE_OFF_FLAG);
   wire hit_win = ((i_paddr & ~SAE_WIN_MASK) == SAE_OFF_RWIN);
   wire [3:0] win_idx = i_paddr[SAE_WIN_LSB +: 4];
   wire win_rd = acc && hit_win && !i_pwrite && !busy;
   wire apb_wr = acc && hit_win && i_pwrite && !busy;
   logic acc_err;
   logic [SAE_DW-1:0] rd_mux;

   always_comb
   begin
      acc_err = 1'b0;
      rd_mux = '0;
      if (hit_ctrl)
      begin
         acc_err = busy;
      end
      else if (hit_list)
      begin
         acc_err = busy && i_pwrite;
         rd_mux = {23'h0, list_reg};
      end
      else if (hit_stat)
      begin
         acc_err = i_pwrite;
         rd_mux[SAE_ST_BUSY_BIT] = busy;
         rd_mux[SAE_ST_ILL_BIT] = ill_reg;
         rd_mux[SAE_ST_T_BIT] = tbit_reg;
         rd_mux[SAE_FLAG_LSB +: 4] = flags_reg;
      end
      else if (hit_flag)
      begin
         acc_err = busy && i_pwrite;
         rd_mux[SAE_FLAG_LSB +: 4] = flags_reg;
      end
      else if (hit_win)
      begin
         acc_err = busy;
      end
      else
      begin
         acc_err = 1'b1;
      end
   end

   // command fields straight from the write data
   wire sae_op_type w_op = sae_op_type'(i_pwdata[SAE_CTL_OP_LSB +: 4]);
   wire [3:0] w_rs = i_pwdata[SAE_CTL_RS_LSB +: 4];
   wire [3:0] w_rd = i_pwdata[SAE_CTL_RDG_BIT] ? i_pwdata[SAE_CTL_RD_LSB +: 4] : w_rs;
   wire [3:0] w_rt = i_pwdata[SAE_CTL_RT_LSB +: 4];
   wire [9:0] w_imm = i_pwdata[SAE_CTL_IMM_LSB +: 10];
   wire w_form = i_pwdata[SAE_CTL_FORM_BIT];
   wire w_wb = i_pwdata[SAE_CTL_WB_BIT];
   wire start = acc && hit_ctrl && i_pwrite && !busy;
   wire w_legal = legal(w_op, w_rd, w_rs, w_rt, w_imm, w_form, list_reg, w_wb);

   // operation classes
   wire is_pp = (op_reg == SAE_PUSH) || (op_reg == SAE_POP);
   wire is_blk = is_pp || (op_reg == SAE_BLD) || (op_reg == SAE_BST);
   wire is_store = (op_reg == SAE_BST) || (op_reg == SAE_PUSH);
   wire is_sub = (op_reg == SAE_SUB) || (op_reg == SAE_SUBF) || (op_reg == SAE_SBC)
         || (op_reg == SAE_NEG);
   wire use_c = (op_reg == SAE_ADC) || (op_reg == SAE_SBC);
   wire setf = (op_reg != SAE_ADD) && (op_reg != SAE_SUB) && !is_blk;

   // adder shared by the whole add/subtract family
   wire [SAE_DW-1:0] opa = (op_reg == SAE_NEG) ? '0 : ra_data;
   wire [SAE_DW-1:0] opb_raw = (op_reg == SAE_NEG) ? ra_data
         : (form_reg ? {22'h0, imm_reg} : rb_data);
   wire [SAE_DW-1:0] opb = is_sub ? ~opb_raw : opb_raw;
   wire cin = use_c ? flags_reg[1] : is_sub;
   wire [SAE_DW:0] sum = {1'b0, opa} + {1'b0, opb} + {32'h0, cin};
   wire [SAE_DW-1:0] res = sum[SAE_DW-1:0];
   wire [3:0] nzcv = {res[SAE_DW-1], res == '0, sum[SAE_DW],
         (opa[SAE_DW-1] == opb[SAE_DW-1]) && (res[SAE_DW-1] != opa[SAE_DW-1])};

   // block address plan
   wire [SAE_DW-1:0] span = 32'({count(list_reg), 2'b00});
   wire [SAE_DW-1:0] first_addr = (op_reg == SAE_PUSH) ? ra_data - span : ra_data;
   wire [SAE_DW-1:0] last_addr = (op_reg == SAE_PUSH) ? first_addr : ra_data + span;
   wire [3:0] cur_reg = reg_of(idx_reg, op_reg);
   wire [3:0] nxt_idx = next_idx(list_reg, idx_reg + 4'h1);
   wire load_pc = (cur_reg == SAE_REG_PC);
   wire do_wb = is_pp || wb_reg;

   // register file port selection
   wire [3:0] ra_addr = busy ? (is_pp ? SAE_REG_SP : rs_reg) : win_idx;
   wire [3:0] rb_addr = (state_reg == ST_FETCH) ? cur_reg : rt_reg;
   wire alu_wr = (state_reg == ST_EXEC) && !is_blk;
   wire ld_wr = (state_reg == ST_XFER) && o_mem_req && i_mem_ack && !is_store;
   wire wb_wr = (state_reg == ST_WBACK) && do_wb;
   wire rf_we = alu_wr || ld_wr || wb_wr || apb_wr;
   wire [3:0] rf_wa = alu_wr ? rd_reg : ld_wr ? cur_reg
         : wb_wr ? (is_pp ? SAE_REG_SP : rs_reg) : win_idx;
   wire [SAE_DW-1:0] ld_val = load_pc ? (i_mem_rdata & ~32'h1) : i_mem_rdata;
   // writeback uses the end address latched at exec, since loads may change the base port
   wire [SAE_DW-1:0] rf_wd = alu_wr ? res : ld_wr ? ld_val : wb_wr ? end_reg : i_pwdata;

   sae_regfile #(
      .DW(SAE_DW),
      .DEPTH(16)
   ) u_regs (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_ra_addr(ra_addr),
      .o_ra_data(ra_data),
      .i_rb_addr(rb_addr),
      .o_rb_data(rb_data),
      .i_we(rf_we),
      .i_wa(rf_wa),
      .i_wd(rf_wd)
   );

   // apb slave; a register-window read waits one cycle for the file
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_prdata <= '0;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         rdpend_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         if (win_rd && !rdpend_reg)
         begin
            rdpend_reg <= 1'b1;
         end
         else if (acc)
         begin
            rdpend_reg <= 1'b0;
            o_pready <= 1'b1;
            o_pslverr <= acc_err;
            o_prdata <= rdpend_reg ? ra_data : (i_pwrite ? '0 : rd_mux);
         end
      end
   end

   // execution sequencer
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_reg <= ST_IDLE;
         op_reg <= SAE_ADD;
         rd_reg <= 4'h0;
         rs_reg <= 4'h0;
         rt_reg <= 4'h0;
         imm_reg <= 10'h000;
         form_reg <= 1'b0;
         wb_reg <= 1'b0;
         list_reg <= 9'h000;
         idx_reg <= 4'h0;
         addr_reg <= '0;
         end_reg <= '0;
         flags_reg <= SAE_FLAGS_RST;
         tbit_reg <= SAE_T_RST;
         ill_reg <= 1'b0;
         o_mem_req <= 1'b0;
         o_mem_we <= 1'b0;
         o_mem_addr <= '0;
         o_mem_wdata <= '0;
         o_branch <= 1'b0;
      end
      else if (i_ce)
      begin
         o_branch <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (acc && i_pwrite && hit_list)
               begin
                  list_reg <= i_pwdata[8:0];
               end
               if (acc && i_pwrite && hit_flag)
               begin
                  flags_reg <= i_pwdata[SAE_FLAG_LSB +: 4];
               end
               if (start)
               begin
                  op_reg <= w_op;
                  rd_reg <= w_rd;
                  rs_reg <= w_rs;
                  rt_reg <= w_rt;
                  imm_reg <= w_imm;
                  form_reg <= w_form;
                  wb_reg <= w_wb;
                  ill_reg <= !w_legal;
                  state_reg <= w_legal ? ST_READ : ST_IDLE;
               end
            end
            ST_READ: state_reg <= ST_EXEC;
            ST_EXEC:
            begin
               if (!is_blk)
               begin
                  if (setf)
                  begin
                     flags_reg <= nzcv;
                  end
                  state_reg <= ST_IDLE;
               end
               else if (ra_data[1:0] != 2'h0)
               begin
                  // unaligned base is refused before any bus traffic
                  ill_reg <= 1'b1;
                  state_reg <= ST_IDLE;
               end
               else
               begin
                  addr_reg <= first_addr;
                  end_reg <= last_addr;
                  idx_reg <= next_idx(list_reg, 4'h0);
                  state_reg <= is_store ? ST_FETCH : ST_XFER;
               end
            end
            ST_FETCH: state_reg <= ST_XFER;
            ST_XFER:
            begin
               if (!o_mem_req)
               begin
                  o_mem_req <= 1'b1;
                  o_mem_we <= is_store;
                  o_mem_addr <= addr_reg;
                  o_mem_wdata <= is_store ? rb_data : '0;
               end
               else if (i_mem_ack)
               begin
                  o_mem_req <= 1'b0;
                  o_mem_we <= 1'b0;
                  if (ld_wr && load_pc)
                  begin
                     tbit_reg <= i_mem_rdata[0];
                  end
                  addr_reg <= addr_reg + SAE_WORD;
                  idx_reg <= nxt_idx;
                  if (nxt_idx == SAE_LIST_END)
                  begin
                     state_reg <= ST_WBACK;
                  end
                  else
                  begin
                     state_reg <= is_store ? ST_FETCH : ST_XFER;
                  end
               end
            end
            ST_WBACK:
            begin
               // branch is signalled only once the whole pop is done
               o_branch <= (op_reg == SAE_POP) && list_reg[SAE_LIST_XTRA];
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // sae_exec
`default_nettype wire

// ===== sae_pkg.sv
package sae_pkg;
   localparam int SAE_DW = 32;
   localparam int SAE_AW = 8;
   // apb byte offsets
   localparam logic [7:0] SAE_OFF_CTRL = 8'h00;
   localparam logic [7:0] SAE_OFF_LIST = 8'h04;
   localparam logic [7:0] SAE_OFF_STAT = 8'h08;
   localparam logic [7:0] SAE_OFF_FLAG = 8'h0C;
   localparam logic [7:0] SAE_OFF_RWIN = 8'h40;
   localparam logic [7:0] SAE_WIN_MASK = 8'h3F;
   localparam int SAE_WIN_LSB = 2;
   // command word fields
   localparam int SAE_CTL_OP_LSB = 0;
   localparam int SAE_CTL_RD_LSB = 4;
   localparam int SAE_CTL_RS_LSB = 8;
   localparam int SAE_CTL_RT_LSB = 12;
   localparam int SAE_CTL_IMM_LSB = 16;
   localparam int SAE_CTL_FORM_BIT = 26;
   localparam int SAE_CTL_RDG_BIT = 27;
   localparam int SAE_CTL_WB_BIT = 28;
   // status and flag word fields
   localparam int SAE_ST_BUSY_BIT = 0;
   localparam int SAE_ST_ILL_BIT = 1;
   localparam int SAE_ST_T_BIT = 2;
   localparam int SAE_FLAG_LSB = 4;
   localparam int SAE_LIST_XTRA = 8;
   localparam logic [3:0] SAE_LIST_END = 4'h9;
   localparam logic [3:0] SAE_REG_SP = 4'hD;
   localparam logic [3:0] SAE_REG_LR = 4'hE;
   localparam logic [3:0] SAE_REG_PC = 4'hF;
   localparam int SAE_HIGH_BIT = 3;
   localparam logic [9:0] SAE_IMM3_MAX = 10'h007;
   localparam logic [9:0] SAE_IMM8_MAX = 10'h0FF;
   localparam logic [9:0] SAE_SPIMM_MAX = 10'h1FC;
   localparam logic [9:0] SAE_PCIMM_MAX = 10'h3FC;
   localparam logic [31:0] SAE_WORD = 32'h0000_0004;
   localparam logic [3:0] SAE_FLAGS_RST = 4'h0;
   localparam logic SAE_T_RST = 1'b1;
   typedef enum logic [3:0] {
      SAE_ADD, SAE_ADDS, SAE_ADC, SAE_SUB, SAE_SUBF, SAE_SBC, SAE_NEG,
      SAE_BLD, SAE_BST, SAE_PUSH, SAE_POP
   } sae_op_type;
   typedef enum logic [2:0] {
      ST_IDLE, ST_READ, ST_EXEC, ST_FETCH, ST_XFER, ST_WBACK
   } sae_state_type;
endpackage

// ===== sae_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module sae_regfile #(
   parameter int DW = 32,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic [AW-1:0] i_ra_addr,
   output logic [DW-1:0] o_ra_data,
   input wire logic [AW-1:0] i_rb_addr,
   output logic [DW-1:0] o_rb_data,
   input wire logic i_we,
   input wire logic [AW-1:0] i_wa,
   input wire logic [DW-1:0] i_wd
);
   logic [DW-1:0] mem [DEPTH];

   // storage itself is not reset; software loads it before use
   always_ff @(posedge i_clock)
   begin
      if (i_ce && i_we)
      begin
         mem[i_wa] <= i_wd;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_ra_data <= '0;
         o_rb_data <= '0;
      end
      else if (i_ce)
      begin
         o_ra_data <= mem[i_ra_addr];
         o_rb_data <= mem[i_rb_addr];
      end
   end
endmodule // sae_regfile
`default_nettype wire

// ===== sae_exec_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sae_exec_monitor
   import sae_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_mem_req,
   input wire logic o_mem_we,
   input wire logic [SAE_DW-1:0] o_mem_addr,
   input wire logic [SAE_DW-1:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic o_branch
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   // cycles since the last accepted word; 8'hFF means none recent
   logic [7:0] gap_reg;
   logic [31:0] last_reg;
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         gap_reg <= 8'hFF;
         last_reg <= 32'h0;
      end
      else if (o_mem_req && i_mem_ack && i_ce)
      begin
         gap_reg <= 8'h00;
         last_reg <= o_mem_addr;
      end
      else if (gap_reg != 8'hFF)
         gap_reg <= gap_reg + 8'h01;
   end
   sequence s_wait;
      o_mem_req && !i_mem_ack;
   endsequence
   sequence s_accept;
      o_mem_req && i_mem_ack && i_ce;
   endsequence
   a_req_held: assert property (s_wait |=> o_mem_req && $stable(o_mem_addr)
      && $stable(o_mem_we) && $stable(o_mem_wdata)) else $error("memory request not held");
   a_req_release: assert property (s_accept |=> !o_mem_req)
      else $error("memory request kept after acknowledge");
   a_addr_word: assert property (o_mem_req |-> o_mem_addr[1:0] == 2'b00)
      else $error("unaligned memory address");
   // only a next word of the same transfer can start this soon after an accept
   a_addr_step: assert property ($rose(o_mem_req) && gap_reg <= 8'h03
      |-> o_mem_addr == last_reg + SAE_WORD) else $error("block words not ascending by four");
   a_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   a_ready_access: assert property (o_pready |-> i_psel && i_penable)
      else $error("ready outside an access phase");
   a_err_ready: assert property (o_pslverr |-> o_pready)
      else $error("error without ready");
   a_branch_pulse: assert property (o_branch |=> !o_branch)
      else $error("branch longer than one cycle");
   a_branch_late: assert property (o_branch |-> gap_reg <= 8'h04 && !o_mem_req)
      else $error("branch not right after the last load");
endmodule // sae_exec_monitor
`default_nettype wire

// ===== test_stack_multi_and_addsub_exec.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module test_stack_multi_and_addsub_exec
   import sae_pkg::*;
;
   logic i_clock = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_mem_ack = 1'b0;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, e;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0, i_mem_rdata = 32'h0, o_prdata, o_mem_addr, o_mem_wdata, q;
   logic o_pready, o_pslverr, o_mem_req, o_mem_we, o_branch;
   logic [31:0] mem [0:255];
   logic [31:0] alog [$];
   logic [31:0] bc [0:9];
   logic [8:0] bl [0:9];
   int n_fail = 0, total_checks = 0, n_br = 0, lat = 0, wcnt = 0, n;
   sae_exec sae_exec_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ce(i_ce),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
      .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
      .o_branch(o_branch));
   initial
   begin
      forever #20 i_clock = ~i_clock;
   end
   // memory side: load data is only valid with ack, garbage otherwise
   always @(posedge i_clock)
   begin
      n_br <= n_br + int'(o_branch === 1'b1);
      if (o_mem_req === 1'b1 && i_mem_ack !== 1'b1 && wcnt >= lat)
      begin
         i_mem_ack <= 1'b1;
         i_mem_rdata <= mem[o_mem_addr[9:2]];
         if (o_mem_we)
            mem[o_mem_addr[9:2]] <= o_mem_wdata;
         alog.push_back(o_mem_addr);
      end
      else
      begin
         i_mem_ack <= 1'b0;
         i_mem_rdata <= ~i_mem_rdata;
         wcnt <= (o_mem_req === 1'b1) ? wcnt + 1 : 0;
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge i_clock);
         k++;
      end
      while (o_pready !== 1'b1 && k < 20);
      q = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (o_pready !== 1'b1)
      begin
         n_fail++;
         complete_run();
      end
   endtask
   task automatic setr(input int i, input logic [31:0] v);
      apb(1'b1, SAE_OFF_RWIN + 8'(4 * i), v);
   endtask
   task automatic chkr(input int i, input logic [31:0] v);
      apb(1'b0, SAE_OFF_RWIN + 8'(4 * i), 32'h0);
      `CHK("register", v, q)
   endtask
   task automatic run(input logic [31:0] c, input logic [3:0] fl, input logic ill);
      int k;
      apb(1'b1, SAE_OFF_CTRL, c);
      k = 0;
      do
      begin
         apb(1'b0, SAE_OFF_STAT, 32'h0);
         k++;
      end
      while (q[SAE_ST_BUSY_BIT] !== 1'b0 && k < 50);
      if (q[SAE_ST_BUSY_BIT] !== 1'b0)
      begin
         n_fail++;
         complete_run();
      end
      `CHK("flags", fl, q[SAE_FLAG_LSB+:4])
      `CHK("illegal", ill, q[SAE_ST_ILL_BIT])
   endtask
   // fgw packs {writeback, destination given, immediate form}
   function automatic logic [31:0] cw(input sae_op_type op, input logic [3:0] rd, rs, rt,
         input logic [9:0] imm, input logic [2:0] fgw);
      cw = 32'h0;
      cw[SAE_CTL_OP_LSB+:4] = op;
      cw[SAE_CTL_RD_LSB+:4] = rd;
      cw[SAE_CTL_RS_LSB+:4] = rs;
      cw[SAE_CTL_RT_LSB+:4] = rt;
      cw[SAE_CTL_IMM_LSB+:10] = imm;
      cw[SAE_CTL_FORM_BIT+:3] = fgw;
   endfunction
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 32'hA500_0000 + 32'(i);
      repeat (8) @(posedge i_clock);
      i_rst_b <= 1'b1;
      apb(1'b0, SAE_OFF_STAT, 32'h0);
      `CHK("status", 32'h0000_0004, q)
      apb(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", 1'b1, e)
      apb(1'b1, SAE_OFF_STAT, 32'h0);
      `CHK("read only", 1'b1, e)
      setr(0, 32'hFFFF_FF01);
      run(cw(SAE_ADDS, 0, 0, 0, 10'h0FF, 3'b011), 4'b0110, 1'b0);
      chkr(0, 32'h0);
      apb(1'b1, SAE_OFF_FLAG, 32'h20);
      setr(1, 32'h7FFF_FFFF);
      setr(2, 32'h0);
      run(cw(SAE_ADC, 7, 1, 2, 10'h0, 3'b000), 4'b1001, 1'b0);
      chkr(1, 32'h8000_0000);
      run(cw(SAE_SBC, 1, 1, 2, 10'h0, 3'b010), 4'b0011, 1'b0);
      chkr(1, 32'h7FFF_FFFF);
      setr(4, 32'h1);
      run(cw(SAE_NEG, 3, 4, 0, 10'h0, 3'b010), 4'b1000, 1'b0);
      chkr(3, 32'hFFFF_FFFF);
      setr(6, 32'hA);
      run(cw(SAE_SUB, 5, 6, 0, 10'h7, 3'b011), 4'b1000, 1'b0);
      chkr(5, 32'h3);
      setr(0, 32'h6);
      setr(1, 32'h5);
      run(cw(SAE_SUBF, 2, 0, 1, 10'h0, 3'b010), 4'b0010, 1'b0);
      chkr(2, 32'h1);
      setr(8, 32'h1);
      setr(9, 32'h2);
      run(cw(SAE_ADD, 0, 8, 9, 10'h0, 3'b000), 4'b0010, 1'b0);
      chkr(8, 32'h3);
      setr(13, 32'h100);
      setr(15, 32'h1000);
      run(cw(SAE_ADD, 13, 13, 0, 10'h1FC, 3'b011), 4'b0010, 1'b0);
      chkr(13, 32'h2FC);
      run(cw(SAE_SUB, 13, 13, 0, 10'h1FC, 3'b011), 4'b0010, 1'b0);
      chkr(13, 32'h100);
      run(cw(SAE_ADD, 0, 15, 0, 10'h3FC, 3'b011), 4'b0010, 1'b0);
      chkr(0, 32'h13FC);
      setr(0, 32'h1111_1111);
      setr(2, 32'h2222_2222);
      setr(14, 32'h0000_0201);
      alog.delete();
      apb(1'b1, SAE_OFF_LIST, 32'h105);
      run(cw(SAE_PUSH, 0, 0, 0, 10'h0, 3'b000), 4'b0010, 1'b0);
      `CHK("count", 3, alog.size())
      for (int i = 0; i < 3; i++)
         `CHK("address", 32'hF4 + 32'(4 * i), alog[i])
      `CHK("low word", 32'h1111_1111, mem[61])
      `CHK("high word", 32'h0000_0201, mem[63])
      chkr(13, 32'hF4);
      lat = 3;
      alog.delete();
      apb(1'b1, SAE_OFF_LIST, 32'h10A);
      run(cw(SAE_POP, 0, 0, 0, 10'h0, 3'b000), 4'b0010, 1'b0);
      `CHK("thumb", 1'b1, q[SAE_ST_T_BIT])
      `CHK("pop base", 32'hF4, alog[0])
      chkr(1, 32'h1111_1111);
      chkr(3, 32'h2222_2222);
      chkr(15, 32'h200);
      chkr(13, 32'h100);
      `CHK("branch", 1, n_br)
      lat = 0;
      // an even return word must clear the state bit, which reset leaves set
      setr(14, 32'h0000_0300);
      apb(1'b1, SAE_OFF_LIST, 32'h100);
      run(cw(SAE_PUSH, 0, 0, 0, 10'h0, 3'b000), 4'b0010, 1'b0);
      run(cw(SAE_POP, 0, 0, 0, 10'h0, 3'b000), 4'b0010, 1'b0);
      `CHK("tbit", 1'b0, q[SAE_ST_T_BIT])
      chkr(15, 32'h300);
      setr(1, 32'h20);
      setr(2, 32'h5555_0000);
      apb(1'b1, SAE_OFF_LIST, 32'h006);
      run(cw(SAE_BST, 0, 1, 0, 10'h0, 3'b100), 4'b0010, 1'b0);
      `CHK("stored base", 32'h20, mem[8])
      `CHK("stored next", 32'h5555_0000, mem[9])
      chkr(1, 32'h28);
      setr(0, 32'h40);
      apb(1'b1, SAE_OFF_LIST, 32'h009);
      run(cw(SAE_BLD, 0, 0, 0, 10'h0, 3'b000), 4'b0010, 1'b0);
      chkr(0, 32'hA500_0010);
      chkr(3, 32'hA500_0011);
      setr(4, 32'h22);
      bl = '{9'h001, 9'h001, 9'h000, 9'h006, 9'h001, 9'h002, 9'h0, 9'h0, 9'h0, 9'h0};
      bc = '{cw(SAE_BLD, 0, 8, 0, 10'h0, 3'b000), cw(SAE_BST, 0, 4, 0, 10'h0, 3'b100),
         cw(SAE_PUSH, 0, 0, 0, 10'h0, 3'b000), cw(SAE_BST, 0, 2, 0, 10'h0, 3'b100),
         cw(SAE_BLD, 0, 0, 0, 10'h0, 3'b100), cw(SAE_BST, 0, 0, 0, 10'h0, 3'b000),
         cw(SAE_ADD, 13, 13, 0, 10'h1FE, 3'b011), cw(SAE_ADDS, 1, 0, 0, 10'h010, 3'b011),
         cw(SAE_ADC, 0, 8, 1, 10'h0, 3'b000), cw(SAE_ADD, 0, 15, 15, 10'h0, 3'b000)};
      n = alog.size();
      for (int i = 0; i < 10; i++)
      begin
         apb(1'b1, SAE_OFF_LIST, 32'(bl[i]));
         run(bc[i], 4'b0010, 1'b1);
      end
      `CHK("traffic", n, alog.size())
      chkr(13, 32'h100);
      chkr(0, 32'hA500_0010);
      complete_run();
   end
endmodule // test_stack_multi_and_addsub_exec
bind sae_exec sae_exec_monitor sae_exec_monitor_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
   .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
   .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
   .o_branch(o_branch));
`default_nettype wire
